// File: design/tcpwm_pkg.sv
// constants and types shared by the timer capture/compare/pwm block
package tcpwm_pkg;

  // register byte addresses, one byte register per aligned word
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_CNT_HI = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_MOD_HI = 8'h0c;
  localparam logic [7:0] OFF_MOD_LO = 8'h10;
  localparam logic [7:0] OFF_CH_BASE = 8'h14;
  localparam logic [7:0] OFF_CH_STRIDE = 8'h0c;
  localparam logic [7:0] OFF_CH_CTRL = 8'h00;
  localparam logic [7:0] OFF_CH_VHI = 8'h04;
  localparam logic [7:0] OFF_CH_VLO = 8'h08;

  // timer_main_control_reg fields
  localparam int MC_FLAG = 7;
  localparam int MC_IE = 6;
  localparam int MC_CAS = 5;
  localparam int MC_CLK_HI = 4;
  localparam int MC_CLK_LO = 3;

  // channel_control_reg fields
  localparam int CC_FLAG = 7;
  localparam int CC_IE = 6;
  localparam int CC_MSH = 5;
  localparam int CC_MSL = 4;
  localparam int CC_EPH = 3;
  localparam int CC_EPL = 2;

  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] CH_CTRL_RST = 8'h00;
  // bits kept by control writes; the flag bit is read from its own flop
  localparam logic [7:0] RSVD_MASK = 8'h7c;

  // clock_source_field encodings
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  typedef enum logic [1:0] {CAPTURE, COMPARE, EDGE_PWM, CENTER_PWM} tcpwm_mode_t;

  function automatic logic [7:0] tcpwm_ch_addr(input int ch, input logic [7:0] off);
    tcpwm_ch_addr = 8'(int'(OFF_CH_BASE) + ch * int'(OFF_CH_STRIDE) + int'(off));
  endfunction : tcpwm_ch_addr

endpackage : tcpwm_pkg

// File: design/tcpwm_top.sv
// timer with modulus counter and per-channel capture, compare and pwm, apb slave
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module tcpwm_top #(
  parameter int N_CH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_halt_mode,
  input wire logic fixed_tick,
  input wire logic ext_clk_pin,
  input wire logic [N_CH-1:0] ch_in,
  output logic [N_CH-1:0] ch_out,
  output logic [N_CH-1:0] ch_oe,
  output logic irq
);

  logic setup;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic [7:0] main_ctrl;
  logic [1:0] clock_source_field;
  logic center_align_select;
  logic counter_wrap_flag;
  logic wrap_arm;
  logic [15:0] cnt;
  logic dir_down;
  logic [15:0] modulus;
  logic [15:0] mod_buf;
  logic mod_hw;
  logic mod_lw;
  logic cnt_lat;
  logic [15:0] cnt_buf;
  logic ext_q;
  logic tick;
  logic src_tick;
  logic [15:0] term;
  logic cnt_wr;
  logic wrap_evt;
  logic at_load;
  logic cnt_moved;
  logic step_down;
  logic [7:0] ch_ctrl [N_CH];
  logic [15:0] ch_val [N_CH];
  logic ch_flag [N_CH];
  logic [N_CH-1:0] ch_irq;
  logic [N_CH-1:0] hit_ch;
  logic [31:0] next_prdata;
  logic next_err;

  assign setup = psel & ~penable;
  assign wr = ce & psel & penable & pwrite;
  assign rd = ce & psel & penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign clock_source_field = {main_ctrl[tcpwm_pkg::MC_CLK_HI], main_ctrl[tcpwm_pkg::MC_CLK_LO]};
  assign center_align_select = main_ctrl[tcpwm_pkg::MC_CAS];
  assign term = (modulus == tcpwm_pkg::CNT_ZERO) ? tcpwm_pkg::CNT_MAX : modulus;
  assign cnt_wr = wr & (paddr == tcpwm_pkg::OFF_CNT_HI || paddr == tcpwm_pkg::OFF_CNT_LO);

  // counter frozen while debug halt is active
  always_comb
  begin
    case (clock_source_field)
      tcpwm_pkg::CLK_BUS: src_tick = 1'b1;
      tcpwm_pkg::CLK_FIXED: src_tick = fixed_tick;
      tcpwm_pkg::CLK_EXT: src_tick = ext_clk_pin & ~ext_q;
      default: src_tick = 1'b0;
    endcase
    tick = ce & src_tick & ~debug_halt_mode & ~cnt_wr;
  end

  assign wrap_evt = tick & (center_align_select ? (~dir_down & cnt >= term)
                                                : (cnt == term));
  assign at_load = tick & ~dir_down & (cnt == term - tcpwm_pkg::CNT_ONE);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ext_q <= 1'b0;
    else if (ce)
      ext_q <= ext_clk_pin;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt <= tcpwm_pkg::CNT_ZERO;
      dir_down <= 1'b0;
      cnt_moved <= 1'b0;
      step_down <= 1'b0;
    end
    else if (ce)
    begin
      cnt_moved <= tick;
      if (cnt_wr)
      begin
        cnt <= tcpwm_pkg::CNT_ZERO;
        dir_down <= 1'b0;
      end
      else if (tick)
      begin
        if (center_align_select)
        begin
          if (!dir_down && cnt >= term)
          begin
            cnt <= cnt - tcpwm_pkg::CNT_ONE;
            dir_down <= 1'b1;
            step_down <= 1'b1;
          end
          else if (dir_down && cnt == tcpwm_pkg::CNT_ZERO)
          begin
            cnt <= tcpwm_pkg::CNT_ONE;
            dir_down <= 1'b0;
            step_down <= 1'b0;
          end
          else
          begin
            cnt <= dir_down ? cnt - tcpwm_pkg::CNT_ONE : cnt + tcpwm_pkg::CNT_ONE;
            step_down <= dir_down;
          end
        end
        else
        begin
          cnt <= (cnt == term) ? tcpwm_pkg::CNT_ZERO : cnt + tcpwm_pkg::CNT_ONE;
          dir_down <= 1'b0;
          step_down <= 1'b0;
        end
      end
    end
  end

  // counter read coherency: first byte read snapshots the whole count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_lat <= 1'b0;
      cnt_buf <= tcpwm_pkg::CNT_ZERO;
    end
    else if (ce)
    begin
      if (cnt_wr)
        cnt_lat <= 1'b0;
      else if (rd && (paddr == tcpwm_pkg::OFF_CNT_HI || paddr == tcpwm_pkg::OFF_CNT_LO))
      begin
        cnt_lat <= ~cnt_lat;
        if (!cnt_lat)
          cnt_buf <= cnt;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      main_ctrl <= tcpwm_pkg::MAIN_RST;
    else if (ce && wr && paddr == tcpwm_pkg::OFF_MAIN)
      main_ctrl <= wbyte & tcpwm_pkg::RSVD_MASK;
  end

  // set wins over clear; an event also disarms the pending clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      counter_wrap_flag <= 1'b0;
      wrap_arm <= 1'b0;
    end
    else if (ce)
    begin
      if (wrap_evt)
      begin
        counter_wrap_flag <= 1'b1;
        wrap_arm <= 1'b0;
      end
      else if (wr && paddr == tcpwm_pkg::OFF_MAIN)
      begin
        if (wrap_arm && !wbyte[tcpwm_pkg::MC_FLAG])
          counter_wrap_flag <= 1'b0;
        wrap_arm <= 1'b0;
      end
      else if (rd && paddr == tcpwm_pkg::OFF_MAIN && counter_wrap_flag)
        wrap_arm <= 1'b1;
    end
  end

  // modulus bytes land in a buffer and move as one 16-bit value
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      modulus <= tcpwm_pkg::CNT_ZERO;
      mod_buf <= tcpwm_pkg::CNT_ZERO;
      mod_hw <= 1'b0;
      mod_lw <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && paddr == tcpwm_pkg::OFF_MAIN)
      begin
        mod_hw <= 1'b0;
        mod_lw <= 1'b0;
      end
      else if (wr && paddr == tcpwm_pkg::OFF_MOD_HI)
      begin
        mod_buf[15:8] <= wbyte;
        mod_hw <= 1'b1;
      end
      else if (wr && paddr == tcpwm_pkg::OFF_MOD_LO)
      begin
        mod_buf[7:0] <= wbyte;
        mod_lw <= 1'b1;
      end
      else if (mod_hw && mod_lw && (clock_source_field == tcpwm_pkg::CLK_OFF || tick))
      begin
        modulus <= mod_buf;
        mod_hw <= 1'b0;
        mod_lw <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < N_CH; i++)
  begin : g_ch
    localparam logic [7:0] A_CTRL = tcpwm_pkg::tcpwm_ch_addr(i, tcpwm_pkg::OFF_CH_CTRL);
    localparam logic [7:0] A_VHI = tcpwm_pkg::tcpwm_ch_addr(i, tcpwm_pkg::OFF_CH_VHI);
    localparam logic [7:0] A_VLO = tcpwm_pkg::tcpwm_ch_addr(i, tcpwm_pkg::OFF_CH_VLO);
    tcpwm_pkg::tcpwm_mode_t mode;
    logic [15:0] vbuf;
    logic vhw;
    logic vlw;
    logic pin_q;
    logic arm;
    logic edge_polarity_hi;
    logic edge_polarity_lo;
    logic cap_evt;
    logic match;
    logic ctrl_wr;
    logic val_rd;

    assign edge_polarity_hi = ch_ctrl[i][tcpwm_pkg::CC_EPH];
    assign edge_polarity_lo = ch_ctrl[i][tcpwm_pkg::CC_EPL];
    assign ctrl_wr = wr & (paddr == A_CTRL);
    assign val_rd = rd & (paddr == A_VHI || paddr == A_VLO);
    assign hit_ch[i] = (paddr == A_CTRL) | (paddr == A_VHI) | (paddr == A_VLO);

    always_comb
    begin
      if (center_align_select)
        mode = tcpwm_pkg::CENTER_PWM;
      else if (ch_ctrl[i][tcpwm_pkg::CC_MSH])
        mode = tcpwm_pkg::EDGE_PWM;
      else if (ch_ctrl[i][tcpwm_pkg::CC_MSL])
        mode = tcpwm_pkg::COMPARE;
      else
        mode = tcpwm_pkg::CAPTURE;
    end

    // capture ignores the tick so it keeps running under debug halt
    assign cap_evt = ce & (mode == tcpwm_pkg::CAPTURE) & ((edge_polarity_lo & ch_in[i] & ~pin_q)
                   | (edge_polarity_hi & ~ch_in[i] & pin_q));
    assign match = ce & cnt_moved & (mode != tcpwm_pkg::CAPTURE) & (cnt == ch_val[i]);
    assign ch_irq[i] = ch_flag[i] & ch_ctrl[i][tcpwm_pkg::CC_IE];

    always_ff @(posedge clk)
    begin
      if (sys_rst)
        pin_q <= 1'b0;
      else if (ce)
        pin_q <= ch_in[i];
    end

    always_ff @(posedge clk)
    begin
      if (sys_rst)
        ch_ctrl[i] <= tcpwm_pkg::CH_CTRL_RST;
      else if (ctrl_wr)
        ch_ctrl[i] <= wbyte & tcpwm_pkg::RSVD_MASK;
    end

    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        ch_flag[i] <= 1'b0;
        arm <= 1'b0;
      end
      else if (ce)
      begin
        if (cap_evt || match)
        begin
          ch_flag[i] <= 1'b1;
          arm <= 1'b0;
        end
        else if (ctrl_wr)
        begin
          if (arm && !wbyte[tcpwm_pkg::CC_FLAG])
            ch_flag[i] <= 1'b0;
          arm <= 1'b0;
        end
        else if (rd && paddr == A_CTRL && ch_flag[i])
          arm <= 1'b1;
      end
    end

    // value buffer; capture overwrites the value directly
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        ch_val[i] <= tcpwm_pkg::CNT_ZERO;
        vbuf <= tcpwm_pkg::CNT_ZERO;
        vhw <= 1'b0;
        vlw <= 1'b0;
      end
      else if (ce)
      begin
        if (cap_evt)
          ch_val[i] <= cnt;
        if (ctrl_wr)
        begin
          vhw <= 1'b0;
          vlw <= 1'b0;
        end
        else if (wr && (paddr == A_VHI || paddr == A_VLO) && mode != tcpwm_pkg::CAPTURE)
        begin
          if (debug_halt_mode)
          begin
            if (paddr == A_VHI)
              ch_val[i][15:8] <= wbyte;
            else
              ch_val[i][7:0] <= wbyte;
          end
          else if (paddr == A_VHI)
          begin
            vbuf[15:8] <= wbyte;
            vhw <= 1'b1;
          end
          else
          begin
            vbuf[7:0] <= wbyte;
            vlw <= 1'b1;
          end
        end
        else if (vhw && vlw && (clock_source_field == tcpwm_pkg::CLK_OFF
                 || (mode == tcpwm_pkg::COMPARE ? tick : at_load)))
        begin
          ch_val[i] <= vbuf;
          vhw <= 1'b0;
          vlw <= 1'b0;
        end
      end
    end

    logic vlat;
    logic [15:0] vrbuf;
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        vlat <= 1'b0;
        vrbuf <= tcpwm_pkg::CNT_ZERO;
      end
      else if (ce)
      begin
        if (ctrl_wr)
          vlat <= 1'b0;
        else if (val_rd)
        begin
          vlat <= ~vlat;
          if (!vlat)
            vrbuf <= ch_val[i];
        end
      end
    end

    logic [15:0] rd_val;
    assign rd_val = vlat ? vrbuf : ch_val[i];

    // pin level; edge and center pwm are polarity-relative
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        ch_out[i] <= 1'b0;
        ch_oe[i] <= 1'b0;
      end
      else if (ce)
      begin
        ch_oe[i] <= (mode != tcpwm_pkg::CAPTURE) & (edge_polarity_hi | edge_polarity_lo);
        case (mode)
          tcpwm_pkg::COMPARE:
            if (match)
              case ({edge_polarity_hi, edge_polarity_lo})
                2'h1: ch_out[i] <= ~ch_out[i];
                2'h2: ch_out[i] <= 1'b0;
                2'h3: ch_out[i] <= 1'b1;
                default: ch_out[i] <= ch_out[i];
              endcase
          tcpwm_pkg::EDGE_PWM:
            if (match)
              ch_out[i] <= edge_polarity_lo;
            else if (cnt_moved && cnt == tcpwm_pkg::CNT_ZERO)
              ch_out[i] <= ~edge_polarity_lo;
          tcpwm_pkg::CENTER_PWM:
            if (ch_val[i] == tcpwm_pkg::CNT_ZERO || ch_val[i][15])
              ch_out[i] <= edge_polarity_lo;
            else if (ch_val[i] > modulus)
              ch_out[i] <= ~edge_polarity_lo;
            else if (match)
              ch_out[i] <= step_down ? ~edge_polarity_lo : edge_polarity_lo;
          default: ch_out[i] <= ch_out[i];
        endcase
      end
    end
  end

  // read data prepared in the setup phase so pready can stay high
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      tcpwm_pkg::OFF_MAIN: next_prdata[7:0] = main_ctrl | {counter_wrap_flag, 7'h00};
      tcpwm_pkg::OFF_CNT_HI: next_prdata[7:0] = cnt_lat ? cnt_buf[15:8] : cnt[15:8];
      tcpwm_pkg::OFF_CNT_LO: next_prdata[7:0] = cnt_lat ? cnt_buf[7:0] : cnt[7:0];
      tcpwm_pkg::OFF_MOD_HI: next_prdata[7:0] = modulus[15:8];
      tcpwm_pkg::OFF_MOD_LO: next_prdata[7:0] = modulus[7:0];
      default: next_err = ~|hit_ch;
    endcase
    for (int k = 0; k < N_CH; k++)
    begin
      if (paddr == tcpwm_pkg::tcpwm_ch_addr(k, tcpwm_pkg::OFF_CH_CTRL))
        next_prdata[7:0] = ch_ctrl[k] | {ch_flag[k], 7'h00};
    end
  end

  logic [7:0] ch_rd_byte;
  logic [7:0] g_rd_hi [N_CH];
  logic [7:0] g_rd_lo [N_CH];
  always_comb
  begin
    ch_rd_byte = 8'h00;
    for (int k = 0; k < N_CH; k++)
    begin
      if (paddr == tcpwm_pkg::tcpwm_ch_addr(k, tcpwm_pkg::OFF_CH_VHI))
        ch_rd_byte = g_rd_hi[k];
      if (paddr == tcpwm_pkg::tcpwm_ch_addr(k, tcpwm_pkg::OFF_CH_VLO))
        ch_rd_byte = g_rd_lo[k];
    end
  end

  for (genvar j = 0; j < N_CH; j++)
  begin : g_rd
    assign g_rd_hi[j] = g_ch[j].rd_val[15:8];
    assign g_rd_lo[j] = g_ch[j].rd_val[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else if (ce)
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata <= next_prdata | {24'h000000, ch_rd_byte};
        pslverr <= next_err;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else if (ce)
      irq <= (counter_wrap_flag & main_ctrl[tcpwm_pkg::MC_IE]) | (|ch_irq);
  end

endmodule : tcpwm_top

`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int N = 2;
  localparam logic [7:0] MN = tcpwm_pkg::OFF_MAIN;
  localparam logic [7:0] CH = tcpwm_pkg::OFF_CNT_HI;
  localparam logic [7:0] CL = tcpwm_pkg::OFF_CNT_LO;
  localparam logic [7:0] MH = tcpwm_pkg::OFF_MOD_HI;
  localparam logic [7:0] ML = tcpwm_pkg::OFF_MOD_LO;
  localparam logic [7:0] C0 = tcpwm_pkg::OFF_CH_BASE;
  localparam logic [7:0] VH = C0 + tcpwm_pkg::OFF_CH_VHI;
  localparam logic [7:0] VL = C0 + tcpwm_pkg::OFF_CH_VLO;
  logic clk;
  logic sys_rst;
  logic ce;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic debug_halt_mode;
  logic fixed_tick;
  logic ext_clk_pin;
  logic [N-1:0] drv;
  logic [N-1:0] pin;
  logic [N-1:0] ch_out;
  logic [N-1:0] ch_oe;
  logic irq;
  logic clr;
  logic [1:0] tk;
  int hi_cnt;
  int num_errors;
  int checks;
  int cyc;

  tcpwm_top #(.N_CH(N)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt_mode(debug_halt_mode), .fixed_tick(fixed_tick), .ext_clk_pin(ext_clk_pin),
    .ch_in(pin), .ch_out(ch_out), .ch_oe(ch_oe), .irq(irq)
  );
  tcpwm_pin_model #(.N_CH(N)) pins (
    .clk(clk), .drv(drv), .ch_out(ch_out), .ch_oe(ch_oe), .clr(clr), .pin(pin),
    .hi_cnt(hi_cnt)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // count sources at a quarter of the bus rate
  always @(posedge clk)
  begin
    tk <= tk + 2'h1;
    fixed_tick <= (tk == 2'h0);
    ext_clk_pin <= tk[1];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] r, output logic e);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the run timeout ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    logic e;
    apb(a, 1'b0, 8'h00, r, e);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] r;
    rd(a, r);
    chk(r === x, "register read");
  endtask : rdc

  task automatic t_reset;
    logic [7:0] r;
    logic e;
    rdc(MN, 8'h00);
    rdc(C0, 8'h00);
    apb(8'hf0, 1'b0, 8'h00, r, e);
    chk(e === 1'b1, "unmapped address");
  endtask : t_reset

  task automatic t_count;
    logic [7:0] h;
    logic [7:0] l;
    wr(MH, 8'h00);
    wr(ML, 8'h05);
    wr(MN, 8'h08);
    repeat (20) @(posedge clk);
    // stop first, so no wrap can land between the arming read and the clear
    wr(MN, 8'h00);
    rdc(MN, 8'h80);
    wr(MN, 8'h00);
    rdc(MN, 8'h00);
    rd(CH, h);
    rd(CL, l);
    chk({h, l} <= 16'h0005, "count beyond modulus");
  endtask : t_count

  task automatic t_src(input logic [1:0] s, input int n);
    logic [7:0] h;
    logic [7:0] l;
    wr(CL, 8'h00);
    wr(MN, {3'h0, s, 3'h0});
    repeat (n) @(posedge clk);
    wr(MN, 8'h00);
    rd(CH, h);
    rd(CL, l);
    chk((s == 2'h0) == ({h, l} === 16'h0) && {h, l} <= 16'h5, "count source");
  endtask : t_src

  task automatic pwm(input logic [7:0] c, input logic [15:0] v, input int x);
    wr(C0, c);
    wr(VH, v[15:8]);
    wr(VL, v[7:0]);
    repeat (30) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (60) @(posedge clk);
    #1;
    chk(hi_cnt == x, "pwm high time");
  endtask : pwm

  task automatic t_capture;
    logic [7:0] h;
    logic [7:0] l;
    wr(MN, 8'h08);
    @(posedge clk);
    debug_halt_mode <= 1'b1;
    rd(CH, h);
    rd(CL, l);
    // the flag is still set from the pwm matches; clear it so the irq proves the capture
    rdc(C0, 8'ha8);
    wr(C0, 8'h44);
    // the pin was driven high; let it fall to the outside level before the capture edge
    repeat (3) @(posedge clk);
    chk(irq === 1'b0, "irq before capture");
    drv[0] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(irq === 1'b1, "capture irq");
    rdc(VH, h);
    rdc(VL, l);
    wr(VH, 8'haa);
    rdc(VH, h);
    rdc(C0, 8'hc4);
    wr(C0, 8'h44);
    rdc(C0, 8'h44);
    chk(irq === 1'b0, "irq after clear");
    wr(C0, 8'h08);
    @(posedge clk);
    drv[0] <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(C0, 8'h88);
    @(posedge clk);
    debug_halt_mode <= 1'b0;
  endtask : t_capture

  task automatic t_compare;
    logic [7:0] r;
    wr(MN, 8'h00);
    // clear on match: the pin stands high from the pwm runs, so a missed action shows
    wr(C0, 8'h18);
    wr(VH, 8'h00);
    wr(VL, 8'h03);
    wr(CH, 8'h00);
    rdc(CH, 8'h00);
    rdc(CL, 8'h00);
    wr(MN, 8'h08);
    repeat (10) @(posedge clk);
    rd(C0, r);
    chk(r[7] === 1'b1 && ch_oe[0] === 1'b1, "compare event");
    chk(ch_out[0] === 1'b0, "compare pin action");
  endtask : t_compare

  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite, clr, debug_halt_mode} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    drv = '0;
    tk = 2'h0;
    fixed_tick = 1'b0;
    ext_clk_pin = 1'b0;
    cyc = 0;
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_count();
    t_src(2'h0, 9);
    t_src(2'h1, 1);
    t_src(2'h2, 9);
    t_src(2'h3, 9);
    wr(MN, 8'h08);
    pwm(8'h28, 16'h0002, 20);
    pwm(8'h24, 16'h0002, 40);
    pwm(8'h28, 16'h0000, 0);
    pwm(8'h28, 16'h0007, 60);
    @(posedge clk);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    wr(MN, 8'h28);
    pwm(8'h28, 16'h0002, 24);
    pwm(8'h28, 16'h8003, 0);
    pwm(8'h28, 16'h0007, 60);
    t_capture();
    t_compare();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// File: verification/tcpwm_asserts.sv
// port-level assertions for the timer block
`timescale 1ns/100ps
`default_nettype none
module tcpwm_asserts #(
  parameter int N_CH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [N_CH-1:0] ch_in,
  input wire logic [N_CH-1:0] ch_out,
  input wire logic [N_CH-1:0] ch_oe,
  input wire logic irq
);
  localparam logic [7:0] LIM = 8'(8'h14 + 8'h0c * N_CH);
  // shadows of control writes; the block's own copy is not visible here
  logic [7:0] main_sh;
  logic [7:0] ctl0_sh;
  logic [7:0] ctl1_sh;
  logic ie_any;
  assign ie_any = main_sh[6] | ctl0_sh[6] | ctl1_sh[6];
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      main_sh <= 8'h00;
      ctl0_sh <= 8'h00;
      ctl1_sh <= 8'h00;
    end
    else if (psel && penable && pwrite && ce)
    begin
      if (paddr == 8'h00)
        main_sh <= pwdata[7:0];
      if (paddr == 8'h14)
        ctl0_sh <= pwdata[7:0];
      if (paddr == 8'h20)
        ctl1_sh <= pwdata[7:0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_cap_armed;
    (ctl0_sh[5:2] == 4'h1 && ctl0_sh[6] && !main_sh[5] && ce)[*2];
  endsequence
  sequence s_irq_soon;
    ##[1:4] irq;
  endsequence
  a_rst_outs: assert property ($fell(sys_rst) |-> !pready && !irq && ch_oe == '0 && ch_out == '0)
    else $error("outputs not cleared by reset");
  a_ready_up: assert property ($fell(sys_rst) && ce |=> pready)
    else $error("pready not raised after reset");
  a_ready_stay: assert property (pready |=> pready)
    else $error("pready dropped");
  a_rdata_hi: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_bad_addr: assert property (psel && !penable && ce && paddr >= LIM |=> pslverr)
    else $error("unmapped access without error");
  a_good_addr: assert property (psel && !penable && ce && paddr < LIM && paddr[1:0] == 2'h0
    |=> !pslverr)
    else $error("mapped access flagged as error");
  a_cap_no_oe: assert property ((ctl0_sh[5:4] == 2'h0 && !main_sh[5])[*3] |-> !ch_oe[0])
    else $error("capture channel drives its pin");
  a_pwm_oe: assert property ((ctl0_sh[5:3] == 3'h5 && !main_sh[5] && ce)[*3] |-> ch_oe[0])
    else $error("pwm channel not driving its pin");
  a_irq_masked: assert property ((!ie_any)[*3] |-> !irq)
    else $error("irq with all enables off");
  a_cap_irq: assert property (s_cap_armed ##0 $rose(ch_in[0]) |-> s_irq_soon)
    else $error("capture edge raised no irq");
  a_ce_freeze: assert property (!ce |=> $stable(ch_out) && $stable(ch_oe) && $stable(irq))
    else $error("outputs moved with clock enable low");
endmodule : tcpwm_asserts
bind tcpwm_top tcpwm_asserts #(.N_CH(N_CH)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe), .irq(irq)
);
`default_nettype wire

// File: verification/tcpwm_pin_model.sv
// channel pins: external sources plus a high-time meter on channel 0
`timescale 1ns/100ps
`default_nettype none
module tcpwm_pin_model #(
  parameter int N_CH = 2
) (
  input wire logic clk,
  input wire logic [N_CH-1:0] drv,
  input wire logic [N_CH-1:0] ch_out,
  input wire logic [N_CH-1:0] ch_oe,
  input wire logic clr,
  output logic [N_CH-1:0] pin,
  output int hi_cnt
);
  // a driven pin reads back its own level, an undriven one the outside source
  assign pin = (ch_oe & ch_out) | (~ch_oe & drv);
  always_ff @(posedge clk)
  begin
    if (clr)
      hi_cnt <= 0;
    else if (ch_oe[0] && ch_out[0])
      hi_cnt <= hi_cnt + 1;
  end
endmodule : tcpwm_pin_model
`default_nettype wire
